// File: src/wheel_decoder.sv
`default_nettype none
// Notes on behaviour
// - each phase picks one of eight pins
// - both phases are debounced before counting
// - mode bit: clear common, set double
// - common mode counts when both phases match
// - double mode counts every edge of a phase that moves alone
// - live counter hidden, snapshot not auto-updated
// - load bit copies counter into snapshot
// - decoder reset bit clears the counter
// - reading the snapshot clears it, unless a load lands in the same cycle
// - decoder samples at the 32 kHz rate
module wheel_decoder (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [11:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // wheel pins {port_d_bit7_pin, d6, c3, c2, b7, b6, a3, port_a_bit2_pin}
  input wire logic [wheel_decoder_pkg::PIN_N-1:0] wheel_pins_i
);

  // selects one of the eight synchronised pins
  function automatic logic pick_pin(input logic [wheel_decoder_pkg::PIN_N-1:0] pins,
                                    input logic [wheel_decoder_pkg::SEL_W-1:0] sel);
    pick_pin = pins[sel];
  endfunction

  // register state
  logic [wheel_decoder_pkg::SEL_W-1:0] sel_a_reg;
  logic [wheel_decoder_pkg::SEL_W-1:0] sel_b_reg;
  logic [wheel_decoder_pkg::FILT_W-1:0] filt_reg;
  logic mode_reg;
  logic dec_reset_reg;
  logic [wheel_decoder_pkg::COUNT_W-1:0] snap_reg;
  logic [wheel_decoder_pkg::COUNT_W-1:0] snap_next;
  logic [wheel_decoder_pkg::COUNT_W-1:0] count_reg;
  logic [wheel_decoder_pkg::COUNT_W-1:0] count_next;
  wheel_decoder_pkg::bus_req_type req_reg;
  logic [wheel_decoder_pkg::TICK_W-1:0] tick_cnt_reg;
  logic tick_reg;
  logic [wheel_decoder_pkg::PIN_N-1:0] pin_meta_reg;
  logic [wheel_decoder_pkg::PIN_N-1:0] pin_sync_reg;
  wheel_decoder_pkg::phase_type prev_reg;
  wheel_decoder_pkg::phase_type clean_w;

  // address phase decode
  wire logic take_w;
  wire logic mapped_w;
  wire logic [7:0] idx_w;
  wire logic rd_snap_w;
  assign take_w = hsel_i && hready_i && htrans_i == wheel_decoder_pkg::HTRANS_NONSEQ
                  && hsize_i == wheel_decoder_pkg::HSIZE_WORD;
  assign mapped_w = haddr_i[11:10] == 2'h0 && haddr_i[1:0] == 2'h0;
  assign idx_w = haddr_i[9:2];
  assign rd_snap_w = take_w && !hwrite_i && mapped_w
                     && idx_w == wheel_decoder_pkg::IDX_SNAPSHOT;

  // data phase write strobes
  wire logic wr_w;
  wire logic wr_sel_a_w;
  wire logic wr_sel_b_w;
  wire logic wr_filt_w;
  wire logic wr_mode_w;
  wire logic wr_rst_w;
  wire logic load_w;
  assign wr_w = req_reg.valid && req_reg.write;
  assign wr_sel_a_w = wr_w && req_reg.idx == wheel_decoder_pkg::IDX_SEL_A;
  assign wr_sel_b_w = wr_w && req_reg.idx == wheel_decoder_pkg::IDX_SEL_B;
  assign wr_filt_w = wr_w && req_reg.idx == wheel_decoder_pkg::IDX_FILTER;
  assign wr_mode_w = wr_w && req_reg.idx == wheel_decoder_pkg::IDX_MODE;
  assign wr_rst_w = wr_w && req_reg.idx == wheel_decoder_pkg::IDX_SYS_RESET;
  assign load_w = wr_w && req_reg.idx == wheel_decoder_pkg::IDX_LOAD
                  && hwdata_i[wheel_decoder_pkg::LOAD_BIT];

  // read data mux; the live counter has no address
  logic [31:0] rdata_w;
  always_comb begin
    rdata_w = 32'h0000_0000;
    if (mapped_w) begin
      unique case (idx_w)
        wheel_decoder_pkg::IDX_SNAPSHOT: rdata_w = {24'h00_0000, snap_reg};
        wheel_decoder_pkg::IDX_FILTER: rdata_w = {29'h0000_0000, filt_reg};
        wheel_decoder_pkg::IDX_SEL_A: rdata_w = {29'h0000_0000, sel_a_reg};
        wheel_decoder_pkg::IDX_SEL_B: rdata_w = {29'h0000_0000, sel_b_reg};
        wheel_decoder_pkg::IDX_MODE: rdata_w = {31'h0000_0000, mode_reg};
        wheel_decoder_pkg::IDX_SYS_RESET: rdata_w = {26'h000_0000, dec_reset_reg, 5'h00};
        default: rdata_w = 32'h0000_0000;
      endcase
    end
  end

  // bus handshake: zero wait states, always okay
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_reg <= '0;
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= wheel_decoder_pkg::HRESP_OKAY;
    end else begin
      req_reg.valid <= take_w && mapped_w;
      req_reg.write <= hwrite_i;
      req_reg.idx <= idx_w;
      if (take_w && !hwrite_i) begin
        hrdata_o <= rdata_w;
      end
      hreadyout_o <= 1'b1;
      hresp_o <= wheel_decoder_pkg::HRESP_OKAY;
    end
  end

  // control registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_a_reg <= wheel_decoder_pkg::SEL_A_RST;
      sel_b_reg <= wheel_decoder_pkg::SEL_B_RST;
      filt_reg <= wheel_decoder_pkg::FILT_RST;
      mode_reg <= 1'b0;
      dec_reset_reg <= 1'b0;
    end else begin
      if (wr_sel_a_w) begin
        sel_a_reg <= hwdata_i[wheel_decoder_pkg::SEL_W-1:0];
      end
      if (wr_sel_b_w) begin
        sel_b_reg <= hwdata_i[wheel_decoder_pkg::SEL_W-1:0];
      end
      if (wr_filt_w) begin
        filt_reg <= hwdata_i[wheel_decoder_pkg::FILT_W-1:0];
      end
      if (wr_mode_w) begin
        mode_reg <= hwdata_i[wheel_decoder_pkg::MODE_BIT];
      end
      if (wr_rst_w) begin
        dec_reset_reg <= hwdata_i[wheel_decoder_pkg::DEC_RESET_BIT];
      end
    end
  end

  // slow sampling tick derived from the system clock
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= tick_cnt_reg == wheel_decoder_pkg::TICK_LAST;
      if (tick_cnt_reg == wheel_decoder_pkg::TICK_LAST) begin
        tick_cnt_reg <= '0;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 12'h001;
      end
    end
  end

  // two-stage synchroniser on every pin
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else begin
      pin_meta_reg <= wheel_pins_i;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // pin routing and debouncing of both phases
  wire logic [1:0] raw_w;
  wire logic [1:0] clean_vec_w;
  assign raw_w[1] = pick_pin(pin_sync_reg, sel_a_reg);
  assign raw_w[0] = pick_pin(pin_sync_reg, sel_b_reg);
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_deb
      phase_debounce u_deb (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .hold_i(dec_reset_reg),
        .tick_i(tick_reg),
        .filt_n_i(filt_reg),
        .level_i(raw_w[ch]),
        .clean_o(clean_vec_w[ch])
      );
    end
  endgenerate
  assign clean_w = clean_vec_w;

  // edge detection on the cleaned phases
  wire logic edge_a_w;
  wire logic edge_b_w;
  wire logic step_w;
  wire logic up_w;
  assign edge_a_w = clean_w.a != prev_reg.a && clean_w.b == prev_reg.b;
  assign edge_b_w = clean_w.b != prev_reg.b && clean_w.a == prev_reg.a;
  // double mode: any edge of one phase moving alone; common mode: second phase repeats the first's edge
  assign step_w = mode_reg ? (edge_a_w || edge_b_w)
                  : ((edge_a_w && clean_w.a == clean_w.b)
                     || (edge_b_w && clean_w.a == clean_w.b));
  // a leading: a moves away from b, or b catches up with a
  assign up_w = edge_a_w ? (clean_w.a != clean_w.b) : (clean_w.a == clean_w.b);

  // live counter and snapshot; the snapshot restarts the live count
  always_comb begin
    count_next = count_reg;
    snap_next = snap_reg;
    if (rd_snap_w) begin
      snap_next = '0;
    end
    if (load_w) begin
      snap_next = count_reg;
      count_next = '0;
    end
    if (step_w) begin
      count_next = up_w ? count_next + 8'h01 : count_next - 8'h01;
    end
    if (dec_reset_reg) begin
      count_next = '0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_reg <= '0;
      count_reg <= '0;
      snap_reg <= '0;
    end else begin
      prev_reg <= clean_w;
      count_reg <= count_next;
      snap_reg <= snap_next;
    end
  end

  // checks on the snapshot path, the counter and the slow tick
  // a load strobe in the data phase of a write
  sequence s_load_write;
    load_w;
  endsequence

  // a snapshot read with no load in the same cycle
  sequence s_plain_read;
    rd_snap_w && !load_w;
  endsequence

  // neither a snapshot read nor a load
  sequence s_snap_idle;
    !rd_snap_w && !load_w;
  endsequence

  // common mode with the phases apart, nothing else acting on the counter
  sequence s_common_apart;
    !mode_reg && !dec_reset_reg && !load_w && clean_w.a != clean_w.b;
  endsequence

  // double mode, phase a moved alone, nothing else acting on the counter
  sequence s_double_a_edge;
    mode_reg && !dec_reset_reg && !load_w && edge_a_w;
  endsequence

  // double mode, a rises while b is low: a leads
  sequence s_a_leads;
    mode_reg && !dec_reset_reg && !load_w && edge_a_w && clean_w.a && !clean_w.b;
  endsequence

  chk_snapshot_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_load_write |=> snap_reg == $past(count_reg))
    else $error("snapshot did not take the live count");

  chk_read_clears: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_plain_read |=> snap_reg == 8'h00)
    else $error("snapshot not cleared by its read");

  chk_snapshot_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_snap_idle |=> $stable(snap_reg))
    else $error("snapshot changed without a load or read");

  chk_reset_clears: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    dec_reset_reg |=> count_reg == 8'h00)
    else $error("decoder reset left the counter nonzero");

  chk_common_apart: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_common_apart |=> $stable(count_reg))
    else $error("common mode counted on a single phase edge");

  chk_double_edge: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_double_a_edge |=> count_reg == $past(count_reg) + 8'h01
      || count_reg == $past(count_reg) - 8'h01)
    else $error("double mode missed a phase edge");

  chk_up_direction: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_a_leads |=> count_reg == $past(count_reg) + 8'h01)
    else $error("a leading did not count up");

  chk_tick_restart: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tick_reg |-> tick_cnt_reg == 12'h000)
    else $error("slow tick out of step with its divider");
endmodule // wheel_decoder
`default_nettype wire

// File: src/wheel_decoder_pkg.sv
`default_nettype none
package wheel_decoder_pkg;
  // timing: system clock and the slow sampling rate of the decoder
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned SLOW_CLK_HZ = 32_768;
  localparam int unsigned TICK_CYCLES = CLK_HZ / SLOW_CLK_HZ;
  localparam int unsigned TICK_W = 12;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_SNAPSHOT = 8'hD0;
  localparam logic [7:0] IDX_FILTER = 8'hD1;
  localparam logic [7:0] IDX_SEL_A = 8'hD2;
  localparam logic [7:0] IDX_SEL_B = 8'hD3;
  localparam logic [7:0] IDX_MODE = 8'hD7;
  localparam logic [7:0] IDX_LOAD = 8'hD8;
  localparam logic [7:0] IDX_SYS_RESET = 8'h60;

  // field positions and widths
  localparam int unsigned SEL_W = 3;
  localparam int unsigned FILT_W = 3;
  localparam int unsigned COUNT_W = 8;
  localparam int unsigned DEB_W = 9;
  localparam int unsigned PIN_N = 8;
  localparam int unsigned MODE_BIT = 0;
  localparam int unsigned LOAD_BIT = 0;
  localparam int unsigned DEC_RESET_BIT = 5;

  // reset values
  localparam logic [SEL_W-1:0] SEL_A_RST = 3'h0;
  localparam logic [SEL_W-1:0] SEL_B_RST = 3'h1;
  localparam logic [FILT_W-1:0] FILT_RST = 3'h0;
  localparam logic [DEB_W-1:0] DEB_BASE = 9'h002;

  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // the two cleaned phases travel together
  typedef struct packed {
    logic a;
    logic b;
  } phase_type;

  // latched address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] idx;
  } bus_req_type;
endpackage
`default_nettype wire

// File: src/phase_debounce.sv
`default_nettype none
module phase_debounce (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic hold_i,
  input wire logic tick_i,
  input wire logic [wheel_decoder_pkg::FILT_W-1:0] filt_n_i,
  // data
  input wire logic level_i,
  output logic clean_o
);
  logic [wheel_decoder_pkg::DEB_W-1:0] run_reg;
  logic [wheel_decoder_pkg::DEB_W-1:0] run_next;
  logic clean_next;
  wire logic [wheel_decoder_pkg::DEB_W-1:0] limit_w;
  wire logic differs_w;

  // a new level must persist for 2^(n+1) slow ticks before it is passed on
  assign limit_w = wheel_decoder_pkg::DEB_BASE << filt_n_i;
  assign differs_w = level_i != clean_o;

  // run length counter and output flip
  always_comb begin
    run_next = run_reg;
    clean_next = clean_o;
    if (hold_i || !differs_w) begin
      run_next = '0;
    end else if (tick_i) begin
      if (run_reg + 9'h001 >= limit_w) begin
        clean_next = level_i;
        run_next = '0;
      end else begin
        run_next = run_reg + 9'h001;
      end
    end
  end

  // state
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_reg <= '0;
      clean_o <= 1'b0;
    end else begin
      run_reg <= run_next;
      clean_o <= clean_next;
    end
  end

  // the cleaned level only moves on a slow tick
  chk_flip_on_tick: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !tick_i |=> $stable(clean_o))
    else $error("cleaned phase moved between ticks");
endmodule // phase_debounce
`default_nettype wire

// File: tb/wheel_encoder_model.sv
`default_nettype none
// two-phase wheel: lead phase moves, lag phase follows one segment later
module wheel_encoder_model #(
  parameter int unsigned SEG = 6102
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // step request
  input wire logic step_i,
  input wire logic up_i,
  input wire logic [2:0] sel_a_i,
  input wire logic [2:0] sel_b_i,
  input wire logic [7:0] noise_i,
  // wheel side
  output logic [7:0] pins_o,
  output logic busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic a_reg;
  logic b_reg;
  logic up_reg;
  logic [1:0] ph_reg;
  int unsigned cnt_reg;
  // each step moves both phases by the same kind of edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {a_reg, b_reg, up_reg, ph_reg, cnt_reg} <= '0;
    end else if (ph_reg == 2'h0) begin
      if (step_i) begin
        ph_reg <= 2'h1;
        cnt_reg <= SEG;
        up_reg <= up_i;
        if (up_i) a_reg <= ~a_reg;
        else b_reg <= ~b_reg;
      end
    end else if (cnt_reg != 0) begin
      cnt_reg <= cnt_reg - 1;
    end else if (ph_reg == 2'h1) begin
      ph_reg <= 2'h2;
      cnt_reg <= SEG;
      if (up_reg) b_reg <= ~b_reg;
      else a_reg <= ~a_reg;
    end else begin
      ph_reg <= 2'h0;
    end
  end
  // pins only ever drive the block; unselected pins carry noise
  always_comb begin
    pins_o = noise_i;
    pins_o[sel_a_i] = a_reg;
    pins_o[sel_b_i] = b_reg;
  end
  assign busy_o = (ph_reg != 2'h0);
endmodule // wheel_encoder_model
`default_nettype wire

// File: tb/wheel_decoder_bench.sv
`default_nettype none
module wheel_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SEG = 2 * wheel_decoder_pkg::TICK_CYCLES;
  localparam int unsigned SETTLE = wheel_decoder_pkg::TICK_CYCLES;
  localparam logic [7:0] SNAP = wheel_decoder_pkg::IDX_SNAPSHOT;
  localparam logic [7:0] LOAD = wheel_decoder_pkg::IDX_LOAD;
  localparam logic [7:0] MODE = wheel_decoder_pkg::IDX_MODE;
  localparam logic [7:0] SYSR = wheel_decoder_pkg::IDX_SYS_RESET;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic [7:0] pins;
  logic [7:0] noise = 8'h00;
  logic step = 1'b0;
  logic up = 1'b0;
  logic busy;
  logic [2:0] sel_a = 3'h0;
  logic [2:0] sel_b = 3'h1;
  logic [31:0] seed = 32'h2F23;
  logic [31:0] expq[$];
  logic rd_pend = 1'b0;
  logic dp_pend = 1'b0;
  int bad_count = 0;
  int compares = 0;

  wheel_decoder dut_u (.clk_i(clk), .rst_n_i(rst_n), .hsel_i(1'b1), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .wheel_pins_i(pins));
  wheel_encoder_model #(.SEG(SEG)) enc_u (.clk_i(clk), .rst_n_i(rst_n), .step_i(step),
    .up_i(up), .sel_a_i(sel_a), .sel_b_i(sel_b), .noise_i(noise), .pins_o(pins),
    .busy_o(busy));

  // clock
  initial begin
    forever #5 clk = ~clk;
  end

  // xorshift generator
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  // random noise for the unselected pins
  always @(posedge clk) begin
    seed <= xorshift(seed);
    noise <= seed[7:0] ^ seed[15:8];
  end

  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_resp(input logic got);
    compares++;
    if (got !== wheel_decoder_pkg::HRESP_OKAY) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, wheel_decoder_pkg::HRESP_OKAY);
    end
  endtask

  // every data phase must answer okay; read data is matched against the oldest note
  always @(posedge clk) begin
    if (dp_pend && hready) check_resp(hresp);
    if (rd_pend && hready && expq.size() > 0) check_word(hrdata, expq.pop_front());
    if (hready) rd_pend <= (htrans == wheel_decoder_pkg::HTRANS_NONSEQ) && !hwrite;
    if (hready) dp_pend <= (htrans == wheel_decoder_pkg::HTRANS_NONSEQ);
  end

  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!hready && n < 100);
    if (!hready) begin
      bad_count++;
      final_report();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                     input logic [31:0] exp);
    @(posedge clk);
    htrans <= wheel_decoder_pkg::HTRANS_NONSEQ;
    haddr <= {2'h0, idx, 2'h0};
    hwrite <= w;
    if (!w) expq.push_back(exp);
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
  endtask

  task automatic wheel_step(input logic dir);
    int n;
    @(posedge clk);
    step <= 1'b1;
    up <= dir;
    @(posedge clk);
    step <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (busy && n < 3 * SEG);
    if (busy) begin
      bad_count++;
      final_report();
    end
  endtask

  // hang guard
  initial begin
    repeat (95000) @(posedge clk);
    bad_count++;
    final_report();
  end

  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, wheel_decoder_pkg::IDX_SEL_A, 32'h0, 32'h0);
    bus(1'b0, wheel_decoder_pkg::IDX_SEL_B, 32'h0, 32'h1);
    bus(1'b0, 8'hE0, 32'h0, 32'h0);
    bus(1'b1, MODE, 32'h0, 32'h0);
    wheel_step(1'b1);
    wheel_step(1'b1);
    repeat (SETTLE) @(posedge clk);
    bus(1'b0, SNAP, 32'h0, 32'h0);
    bus(1'b1, LOAD, 32'h1, 32'h0);
    bus(1'b0, SNAP, 32'h0, 32'h2);
    bus(1'b0, SNAP, 32'h0, 32'h0);
    // move both phases to other ports and switch to double mode
    bus(1'b1, wheel_decoder_pkg::IDX_SEL_A, 32'h7, 32'h0);
    sel_a <= 3'h7;
    bus(1'b1, wheel_decoder_pkg::IDX_SEL_B, 32'h4, 32'h0);
    sel_b <= 3'h4;
    bus(1'b0, wheel_decoder_pkg::IDX_SEL_A, 32'h0, 32'h7);
    bus(1'b1, MODE, 32'h1, 32'h0);
    bus(1'b0, MODE, 32'h0, 32'h1);
    // a step that the decoder reset must wipe out
    wheel_step(1'b1);
    repeat (SETTLE) @(posedge clk);
    bus(1'b1, SYSR, 32'h20, 32'h0);
    bus(1'b1, SYSR, 32'h0, 32'h0);
    bus(1'b1, LOAD, 32'h1, 32'h0);
    bus(1'b0, SNAP, 32'h0, 32'h0);
    wheel_step(1'b0);
    wheel_step(1'b0);
    repeat (SETTLE) @(posedge clk);
    bus(1'b1, LOAD, 32'h1, 32'h0);
    bus(1'b0, SNAP, 32'h0, 32'hFC);
    repeat (4) @(posedge clk);
    final_report();
  end
endmodule // wheel_decoder_bench
`default_nettype wire
